// file: pkg/padc_pkg.sv
// Notes on behaviour
// - a sample is taken only at the rising edge of the converter clock.
// - one sample per clock cycle; its result appears exactly three cycles later.
// - result word and out-of-range flag are registered together into the output stage.
// - input tracks while clock low, holds the acquired value while clock high.
// - 14-bit parallel word; pin fourteen is the lsb, pin one the msb.
// - every one of the 16384 codes can be produced; no missing codes.
package padc_pkg;
	localparam int unsigned PADC_WIDTH       = 14;
	localparam int unsigned PADC_LATENCY     = 3;
	localparam int unsigned PADC_CODES       = 16384;
	localparam int unsigned PADC_CLK_NS      = 50;
	localparam int unsigned PADC_MAX_PER_NS  = 1000000;
	localparam int unsigned PADC_MIN_PER_NS  = 800;
	localparam int unsigned PADC_MIN_HALF_NS = 360;
	localparam logic [PADC_WIDTH-1:0] PADC_CODE_MAX = 14'h3FFF;
	localparam logic [PADC_WIDTH-1:0] PADC_CODE_MIN = 14'h0000;
	localparam logic [PADC_WIDTH-1:0] PADC_RST_WORD = 14'h0000;
	localparam logic                  PADC_RST_FLAG = 1'h0;
	localparam logic [PADC_WIDTH:0]   PADC_RST_LVL  = 15'h0000;
endpackage

// file: rtl/padc_core.sv
`timescale 1ns/10ps
module padc_core
	import padc_pkg::*;
(
	input  wire logic                  i_clock,
	input  wire logic                  i_arst_n,
	input  wire logic                  i_conv_clk,
	input  wire logic [PADC_WIDTH:0]   i_analog_code,
	output logic      [PADC_WIDTH-1:0] o_data,
	output logic                       o_out_of_range_flag
);
	// i_analog_code: bits 13..0 give the level, bit 14 marks it beyond
	// full scale; levels below zero are not modelled, so a raised flag
	// here always comes with a full-scale word

	typedef enum logic [1:0] {
		PADC_PH_TRACK = 2'h1,
		PADC_PH_HOLD  = 2'h2
	} padc_phase_t;

	// synchronisers for the converter clock and the level
	logic                  clk_s1_q;
	logic                  clk_s1_d;
	logic                  clk_s2_q;
	logic                  clk_s2_d;
	logic [PADC_WIDTH:0]   in_s1_q;
	logic [PADC_WIDTH:0]   in_s1_d;
	logic [PADC_WIDTH:0]   in_s2_q;
	logic [PADC_WIDTH:0]   in_s2_d;

	// track or hold phase, as seen through the synchroniser
	padc_phase_t           phase_q;
	padc_phase_t           phase_d;

	// level followed while tracking, frozen while holding
	logic [PADC_WIDTH:0]   track_q;
	logic [PADC_WIDTH:0]   track_d;

	// straight binary code of the held level
	logic [PADC_WIDTH:0]   coded;
	logic [PADC_WIDTH-1:0] code_word;
	logic                  code_flag;

	// conversion stages, one per converter clock of latency
	logic [PADC_WIDTH-1:0] pipe_w_q [PADC_LATENCY];
	logic [PADC_WIDTH-1:0] pipe_w_d [PADC_LATENCY];
	logic                  pipe_o_q [PADC_LATENCY];
	logic                  pipe_o_d [PADC_LATENCY];

	// output stage driving the pins
	logic [PADC_WIDTH-1:0] data_q;
	logic [PADC_WIDTH-1:0] data_d;
	logic                  flag_q;
	logic                  flag_d;

	logic                  rise;

	// clamp into straight binary; the flag marks over range and always comes with the full-scale word
	function automatic logic [PADC_WIDTH:0] quantise(
		input logic [PADC_WIDTH:0] lvl
	);
		if (lvl[PADC_WIDTH]) begin
			quantise = {1'h1, PADC_CODE_MAX};
		end else begin
			quantise = {1'h0, lvl[PADC_WIDTH-1:0]};
		end
	endfunction

	// the phase follows the synchronised converter clock level
	function automatic padc_phase_t next_phase(
		input padc_phase_t ph,
		input logic        lvl
	);
		case (ph)
			PADC_PH_TRACK: begin
				if (lvl) begin
					next_phase = PADC_PH_HOLD;
				end else begin
					next_phase = PADC_PH_TRACK;
				end
			end
			PADC_PH_HOLD: begin
				if (lvl) begin
					next_phase = PADC_PH_HOLD;
				end else begin
					next_phase = PADC_PH_TRACK;
				end
			end
			default: begin
				next_phase = PADC_PH_TRACK;
			end
		endcase
	endfunction

	// a rise is a high level met while still tracking; falls start nothing
	function automatic logic is_rise(
		input padc_phase_t ph,
		input logic        lvl
	);
		is_rise = (ph == PADC_PH_TRACK) && lvl;
	endfunction

	// the converter clock and level are asynchronous to i_clock
	always_comb begin
		clk_s1_d = i_conv_clk;
		clk_s2_d = clk_s1_q;
		in_s1_d = i_analog_code;
		in_s2_d = in_s1_q;
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			clk_s1_q <= 1'h0;
			clk_s2_q <= 1'h0;
			in_s1_q <= PADC_RST_LVL;
			in_s2_q <= PADC_RST_LVL;
		end else begin
			clk_s1_q <= clk_s1_d;
			clk_s2_q <= clk_s2_d;
			in_s1_q <= in_s1_d;
			in_s2_q <= in_s2_d;
		end
	end

	always_comb begin
		phase_d = next_phase(phase_q, clk_s2_q);
	end

	// reset to track matches the idle low clock, so no false rise
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			phase_q <= PADC_PH_TRACK;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign rise = is_rise(phase_q, clk_s2_q);

	// track while low, hold while high; the held value is the sample
	always_comb begin
		if (clk_s2_q) begin
			track_d = track_q;
		end else begin
			track_d = in_s2_q;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			track_q <= PADC_RST_LVL;
		end else begin
			track_q <= track_d;
		end
	end

	assign coded = quantise(track_q);
	assign code_word = coded[PADC_WIDTH-1:0];
	assign code_flag = coded[PADC_WIDTH];

	// every stage moves on each rise, so samples keep their order
	always_comb begin
		for (int i = 0; i < PADC_LATENCY; i++) begin
			pipe_w_d[i] = pipe_w_q[i];
			pipe_o_d[i] = pipe_o_q[i];
		end
		if (rise) begin
			pipe_w_d[0] = code_word;
			pipe_o_d[0] = code_flag;
			for (int i = 1; i < PADC_LATENCY; i++) begin
				pipe_w_d[i] = pipe_w_q[i-1];
				pipe_o_d[i] = pipe_o_q[i-1];
			end
		end
	end

	// no time-out anywhere, so arbitrarily slow converter clocks are fine
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < PADC_LATENCY; i++) begin
				pipe_w_q[i] <= PADC_RST_WORD;
				pipe_o_q[i] <= PADC_RST_FLAG;
			end
		end else begin
			for (int i = 0; i < PADC_LATENCY; i++) begin
				pipe_w_q[i] <= pipe_w_d[i];
				pipe_o_q[i] <= pipe_o_d[i];
			end
		end
	end

	// word and flag share one register stage, so they never split
	always_comb begin
		data_d = data_q;
		flag_d = flag_q;
		if (rise) begin
			data_d = pipe_w_q[PADC_LATENCY-1];
			flag_d = pipe_o_q[PADC_LATENCY-1];
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			data_q <= PADC_RST_WORD;
			flag_q <= PADC_RST_FLAG;
		end else begin
			data_q <= data_d;
			flag_q <= flag_d;
		end
	end

	// o_data[0] is the lsb pin, o_data[13] the msb pin
	assign o_data = data_q;
	assign o_out_of_range_flag = flag_q;
endmodule

// file: verification/padc_cap_model.sv
`timescale 1ns/10ps
module padc_cap_model (
	input  wire logic i_clock,
	output logic      o_conv_clk
);
	// first rise well after reset release; each phase 10 cycles
	initial begin
		o_conv_clk = 1'b0;
		repeat (20) @(negedge i_clock);
		forever begin
			o_conv_clk = ~o_conv_clk;
			repeat (10) @(negedge i_clock);
		end
	end
endmodule

// file: verification/padc_core_properties.sv
`timescale 1ns/10ps
module padc_core_properties
	import padc_pkg::*;
(
	input wire logic                  i_clock,
	input wire logic                  i_arst_n,
	input wire logic                  i_conv_clk,
	input wire logic [PADC_WIDTH:0]   i_analog_code,
	input wire logic [PADC_WIDTH-1:0] o_data,
	input wire logic                  o_out_of_range_flag
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	a_moves_on_rise: assert property ($changed({o_data,
		o_out_of_range_flag}) |-> $past(i_conv_clk, 2))
		else $error("output moved without a clock rise");
	a_over_full: assert property (
		o_out_of_range_flag |-> o_data == PADC_CODE_MAX)
		else $error("flag set with a word below full scale");
	a_word_stands: assert property (
		$changed(o_data) |=> $stable(o_data) [*8])
		else $error("word did not stand for the period");
	logic       conv_old_q;
	logic [2:0] rises_q;
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			conv_old_q <= 1'h0;
			rises_q <= 3'h0;
		end else begin
			conv_old_q <= i_conv_clk;
			if (i_conv_clk && !conv_old_q && rises_q != 3'h7) begin
				rises_q <= rises_q + 3'h1;
			end
		end
	end
	a_quiet_at_fall: assert property (
		$fell(i_conv_clk) |=> $stable({o_data, o_out_of_range_flag}) [*8])
		else $error("output moved after a clock fall");
	a_latency_fill: assert property (
		rises_q < 3'h3 |-> o_data == PADC_RST_WORD && !o_out_of_range_flag)
		else $error("result left the pipeline too early");
	a_flag_with_word: assert property (
		$changed(o_out_of_range_flag) |->
		$changed(o_data) || o_data == PADC_CODE_MAX)
		else $error("flag moved apart from its word");
	c_over: cover property (o_out_of_range_flag);
	c_move: cover property ($changed(o_data));
	c_top: cover property (o_data == PADC_CODE_MAX && !o_out_of_range_flag);
endmodule
bind padc_core padc_core_properties chk (.i_clock(i_clock),
	.i_arst_n(i_arst_n), .i_conv_clk(i_conv_clk),
	.i_analog_code(i_analog_code), .o_data(o_data),
	.o_out_of_range_flag(o_out_of_range_flag));

// file: verification/padc_core_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module padc_core_tb;
	import padc_pkg::*;
	logic                  i_clock = 0, i_arst_n = 0, cclk;
	logic [PADC_WIDTH:0]   code = 0, e, q[$];
	logic [PADC_WIDTH-1:0] o_data;
	logic                  o_out_of_range_flag;
	int                    errors = 0, cmp_count = 0, cyc = 0;
	padc_core dut (.i_clock(i_clock), .i_arst_n(i_arst_n),
		.i_conv_clk(cclk), .i_analog_code(code), .o_data(o_data),
		.o_out_of_range_flag(o_out_of_range_flag));
	padc_cap_model cap (.i_clock(i_clock), .o_conv_clk(cclk));
	initial forever #25 i_clock = ~i_clock;
	always @(posedge i_clock) if (++cyc > 5000) begin errors++; wrap_up(); end
	task wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		void'($urandom(57910));
		q.push_back(code);
		repeat (16) @(negedge i_clock);
		i_arst_n = 1'b1;
		repeat (40) begin
			@(negedge cclk); // a fresh level each low phase
			code = $urandom;
			q.push_back(code);
		end
		repeat (2) @(posedge cclk);
		repeat (8) @(negedge i_clock);
		$display("test random stream done");
		wrap_up();
	end
	// garbage while held high: a tracking input stage would catch it
	always @(posedge cclk) begin
		repeat (5) @(negedge i_clock);
		code = $urandom;
	end
	always @(posedge cclk) if (q.size() > 3) begin
		repeat (6) @(negedge i_clock);
		e = q.pop_front();
		`CHK(o_out_of_range_flag, e[14])
		`CHK(o_data, e[14] ? PADC_CODE_MAX : e[13:0])
	end
endmodule
